/* File: logic/twrs_pkg.sv */
`default_nettype none

package twrs_pkg;

	// ----------------------------------------------------------------
	// Clock and link timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ    = 200;
	localparam int unsigned T_SCKL_NS  = 1300;
	localparam int unsigned T_SCKH_NS  = 600;
	// One bit is four equal phases: two low, two high.
	localparam int unsigned PHASE_NS   = T_SCKL_NS / 2;
	localparam int unsigned PHASE_CYC  =
		(PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0]  PHASE_LAST = 8'(PHASE_CYC - 1);

	// ----------------------------------------------------------------
	// Addresses, counts and reset values
	// ----------------------------------------------------------------
	localparam logic [6:0]  DEV_ADDR    = 7'h1B;
	localparam logic [15:0] SWRST_INDEX = 16'h0000;
	localparam logic [15:0] INDEX_RESET = 16'h0000;
	localparam logic [3:0]  BIT_ACK     = 4'h8;
	localparam logic [3:0]  BIT_LAST    = 4'h7;
	localparam logic [3:0]  STEP_WR_END = 4'h5;
	localparam logic [3:0]  STEP_RD_END = 4'h7;

	// ----------------------------------------------------------------
	// Line patterns per phase, bit 0 is phase 0
	// ----------------------------------------------------------------
	localparam logic [3:0]  PAT_START_SCL = 4'h6;
	localparam logic [3:0]  PAT_START_SDA = 4'h3;
	localparam logic [3:0]  PAT_STOP_SCL  = 4'hE;
	localparam logic [3:0]  PAT_STOP_SDA  = 4'hC;
	localparam logic [3:0]  PAT_BIT_SCL   = 4'hC;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		DS_IDLE, DS_RX, DS_ACK_OUT, DS_TX, DS_ACK_IN, DS_IGNORE
	} twrs_dstate_type;

	typedef enum logic [2:0] {
		RL_ADDR, RL_REG, RL_DHI, RL_DLO, RL_RHI, RL_RLO
	} twrs_role_type;

	typedef enum logic {MS_IDLE, MS_RUN} twrs_mstate_type;

	typedef enum logic [1:0] {
		K_START, K_TX, K_RX, K_STOP
	} twrs_kind_type;

endpackage : twrs_pkg

`default_nettype wire

/* File: logic/twrs_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Two-wire link with pull-ups on both lines
// ----------------------------------------------------------------
interface twrs_if;
	logic m_scl_o;
	logic m_scl_oe_n;
	logic m_sda_o;
	logic m_sda_oe_n;
	logic d_sda_o;
	logic d_sda_oe_n;
	logic scl;
	logic sda;

	// A released line floats high; any driver pulls it to its level.
	assign scl = m_scl_oe_n | m_scl_o;
	assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);

	modport device (
		input  scl,
		input  sda,
		output d_sda_o,
		output d_sda_oe_n
	);

	modport master (
		input  sda,
		output m_scl_o,
		output m_scl_oe_n,
		output m_sda_o,
		output m_sda_oe_n
	);
endinterface : twrs_if

`default_nettype wire

/* File: logic/twrs_master.sv */
`timescale 1ns/1ps
`default_nettype none

module twrs_master (
	input  wire logic        i_core_clk,
	input  wire logic        i_reset_n,
	twrs_if.master           bus,
	input  wire logic        i_go,
	input  wire logic        i_read,
	input  wire logic [7:0]  i_reg,
	input  wire logic [15:0] i_wdata,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_nack,
	output logic [15:0]      o_rdata
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	twrs_pkg::twrs_mstate_type state_q;
	twrs_pkg::twrs_kind_type   kind;
	logic [7:0]  cnt_q;
	logic [1:0]  ph_q;
	logic [3:0]  step_q;
	logic [3:0]  bit_q;
	logic        rd_q;
	logic [7:0]  reg_q;
	logic [15:0] wdata_q;
	logic [7:0]  rx_q;
	logic        nack_q;
	logic        done_q;
	logic [15:0] rdata_q;
	logic        sda_m_q;
	logic        sda_s_q;
	logic        scl_oe_n_q;
	logic        sda_oe_n_q;
	logic [7:0]  txb;
	logic        ack_bit;
	logic        scl_lvl;
	logic        sda_lvl;
	wire  logic  tick;
	wire  logic  last_ph;
	wire  logic  is_bit;
	wire  logic  at_ack;
	wire  logic [3:0] end_step;

	// ----------------------------------------------------------------
	// Phase divider and decodes
	// ----------------------------------------------------------------
	assign tick     = (state_q == twrs_pkg::MS_RUN) &&
		(cnt_q == twrs_pkg::PHASE_LAST);
	assign last_ph  = tick && (ph_q == 2'h3);
	assign is_bit   = (kind == twrs_pkg::K_TX) || (kind == twrs_pkg::K_RX);
	assign at_ack   = bit_q == twrs_pkg::BIT_ACK;
	assign end_step = rd_q ? twrs_pkg::STEP_RD_END : twrs_pkg::STEP_WR_END;

	// Step table: write is start, addr, reg, hi, lo, stop.
	always_comb begin
		kind    = twrs_pkg::K_TX;
		txb     = 8'hFF;
		ack_bit = 1'h1;
		unique case (step_q)
			4'h0: kind = twrs_pkg::K_START; // RULE2
			4'h1: txb = {twrs_pkg::DEV_ADDR, 1'h0}; // RULE5
			4'h2: txb = reg_q; // RULE8
			4'h3: begin
				if (rd_q) begin
					kind = twrs_pkg::K_START; // RULE9
				end else begin
					txb = wdata_q[15:8];
				end
			end
			4'h4: txb = rd_q ? {twrs_pkg::DEV_ADDR, 1'h1} : wdata_q[7:0];
			4'h5: begin
				if (rd_q) begin
					kind    = twrs_pkg::K_RX;
					ack_bit = 1'h0; // RULE11
				end else begin
					kind = twrs_pkg::K_STOP;
				end
			end
			4'h6: kind = twrs_pkg::K_RX; // Last byte is not acked.
			default: kind = twrs_pkg::K_STOP; // RULE13
		endcase
	end

	// Line levels for the current phase; idle leaves both released.
	always_comb begin
		scl_lvl = 1'h1;
		sda_lvl = 1'h1;
		if (state_q == twrs_pkg::MS_RUN) begin
			unique case (kind)
				twrs_pkg::K_START: begin
					scl_lvl = twrs_pkg::PAT_START_SCL[ph_q];
					sda_lvl = twrs_pkg::PAT_START_SDA[ph_q];
				end
				twrs_pkg::K_STOP: begin
					scl_lvl = twrs_pkg::PAT_STOP_SCL[ph_q];
					sda_lvl = twrs_pkg::PAT_STOP_SDA[ph_q];
				end
				twrs_pkg::K_TX: begin
					scl_lvl = twrs_pkg::PAT_BIT_SCL[ph_q];
					sda_lvl = at_ack ? 1'h1 : txb[~bit_q[2:0]]; // RULE4
				end
				twrs_pkg::K_RX: begin
					scl_lvl = twrs_pkg::PAT_BIT_SCL[ph_q];
					sda_lvl = at_ack ? ack_bit : 1'h1; // RULE4
				end
			endcase
		end
	end

	// Line drivers and data line synchroniser.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			scl_oe_n_q <= 1'h1;
			sda_oe_n_q <= 1'h1;
			sda_m_q    <= 1'h1;
			sda_s_q    <= 1'h1;
		end else begin
			scl_oe_n_q <= scl_lvl;
			sda_oe_n_q <= sda_lvl;
			sda_m_q    <= bus.sda;
			sda_s_q    <= sda_m_q;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			state_q <= twrs_pkg::MS_IDLE;
			cnt_q   <= 8'h00;
			ph_q    <= 2'h0;
			step_q  <= 4'h0;
			bit_q   <= 4'h0;
			rd_q    <= 1'h0;
			reg_q   <= 8'h00;
			wdata_q <= 16'h0000;
			rx_q    <= 8'h00;
			nack_q  <= 1'h0;
			done_q  <= 1'h0;
			rdata_q <= 16'h0000;
		end else begin
			done_q <= 1'h0;
			cnt_q  <= tick ? 8'h00 : cnt_q + 8'h01;
			if (state_q == twrs_pkg::MS_IDLE) begin
				cnt_q <= 8'h00;
				if (i_go) begin
					state_q <= twrs_pkg::MS_RUN;
					ph_q    <= 2'h0;
					step_q  <= 4'h0;
					bit_q   <= 4'h0;
					nack_q  <= 1'h0;
					rd_q    <= i_read;
					reg_q   <= i_reg;
					wdata_q <= i_wdata;
				end
			end else if (tick) begin
				ph_q <= ph_q + 2'h1;
				// Sample the data line in the middle of the high time.
				if (is_bit && ph_q == 2'h2) begin
					if (kind == twrs_pkg::K_RX && !at_ack) begin
						rx_q <= {rx_q[6:0], sda_s_q}; // RULE16
					end
					if (kind == twrs_pkg::K_TX && at_ack) begin
						nack_q <= sda_s_q;
					end
				end
				if (last_ph) begin
					bit_q <= (is_bit && !at_ack) ? bit_q + 4'h1 : 4'h0;
					if (!is_bit || at_ack) begin
						step_q <= step_q + 4'h1;
						if (kind == twrs_pkg::K_TX && nack_q) begin
							step_q <= end_step;
						end
						if (kind == twrs_pkg::K_RX) begin
							rdata_q <= step_q[0] ? {rx_q, rdata_q[7:0]}
								: {rdata_q[15:8], rx_q};
						end
						if (kind == twrs_pkg::K_STOP) begin
							state_q <= twrs_pkg::MS_IDLE;
							done_q  <= 1'h1;
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus.m_scl_o    = 1'h0;
	assign bus.m_scl_oe_n = scl_oe_n_q;
	assign bus.m_sda_o    = 1'h0;
	assign bus.m_sda_oe_n = sda_oe_n_q;
	assign o_busy         = state_q != twrs_pkg::MS_IDLE;
	assign o_done         = done_q;
	assign o_nack         = nack_q;
	assign o_rdata        = rdata_q;

endmodule : twrs_master

`default_nettype wire

/* File: logic/twrs_device.sv */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1: Target only, never drives the clock.
// RULE2: Data falling, clock high, opens transaction.
// RULE3: Data rising, clock high, returns to idle.
// RULE4: Transmitter releases; receiver acks ninth clock.
// RULE5: Address byte: seven bits, direction last.
// RULE6: Own address is fixed 0x1B.
// RULE7: Matching address is acknowledged.
// RULE8: Write: address, register, data bytes, stop.
// RULE9: Read: set register, repeated start, read.
// RULE10: Read returns sixteen bits as two bytes.
// RULE11: Acked reads advance index to next register.
// RULE12: Index wraps from 0xFFFF to 0x0000.
// RULE13: Read data continues until a stop.
// RULE14: Write to register zero resets everything.
// RULE15: Foreign address: no ack, ignore until start.
// RULE16: Most significant byte and bit first.
module twrs_device (
	input  wire logic        i_core_clk,
	input  wire logic        i_reset_n,
	twrs_if.device           bus,
	output logic             o_wr_stb,
	output logic [15:0]      o_wr_index,
	output logic [15:0]      o_wr_data,
	output logic             o_soft_reset,
	output logic [15:0]      o_rd_index,
	input  wire logic [15:0] i_rd_data
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	twrs_pkg::twrs_dstate_type state_q;
	twrs_pkg::twrs_dstate_type state_d;
	twrs_pkg::twrs_role_type   role_q;
	twrs_pkg::twrs_role_type   role_d;
	logic [3:0]  bit_q;
	logic [3:0]  bit_d;
	logic [7:0]  sh_q;
	logic [7:0]  sh_d;
	logic        nack_q;
	logic        nack_d;
	logic [15:0] index_q;
	logic [15:0] index_d;
	logic [7:0]  hi_q;
	logic [7:0]  hi_d;
	logic [7:0]  lo_q;
	logic [7:0]  lo_d;
	logic        wr_stb_q;
	logic        wr_stb_d;
	logic [15:0] wr_index_q;
	logic [15:0] wr_index_d;
	logic [15:0] wr_data_q;
	logic [15:0] wr_data_d;
	logic        srst_q;
	logic        srst_d;
	logic        sda_oe_n_q;
	logic        scl_m_q;
	logic        scl_s_q;
	logic        scl_p_q;
	logic        sda_m_q;
	logic        sda_s_q;
	logic        sda_p_q;
	wire  logic  scl_rise;
	wire  logic  scl_fall;
	wire  logic  start_det;
	wire  logic  stop_det;
	wire  logic  addr_hit;
	wire  logic  pull_low;

	// ----------------------------------------------------------------
	// Line synchronisers and condition detection
	// ----------------------------------------------------------------
	// Both lines pass two flops; the third stage is the previous level.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			scl_m_q <= 1'h1;
			scl_s_q <= 1'h1;
			scl_p_q <= 1'h1;
			sda_m_q <= 1'h1;
			sda_s_q <= 1'h1;
			sda_p_q <= 1'h1;
		end else begin
			scl_m_q <= bus.scl;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= bus.sda;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	// Edges of the clock line and the two bus conditions.
	assign scl_rise  = scl_s_q && !scl_p_q;
	assign scl_fall  = !scl_s_q && scl_p_q;
	assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q; // RULE2
	assign stop_det  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q; // RULE3
	assign addr_hit  = sh_q[7:1] == twrs_pkg::DEV_ADDR; // RULE6

	// ----------------------------------------------------------------
	// Byte engine
	// ----------------------------------------------------------------
	// Moves happen on clock falls, samples are taken on clock rises.
	always_comb begin
		state_d    = state_q;
		role_d     = role_q;
		bit_d      = bit_q;
		sh_d       = sh_q;
		nack_d     = nack_q;
		index_d    = index_q;
		hi_d       = hi_q;
		lo_d       = lo_q;
		wr_index_d = wr_index_q;
		wr_data_d  = wr_data_q;
		wr_stb_d   = 1'h0;
		srst_d     = 1'h0;
		if (start_det) begin
			state_d = twrs_pkg::DS_RX; // RULE2
			role_d  = twrs_pkg::RL_ADDR; // Any start opens an address byte.
			bit_d   = 4'h0;
		end else if (stop_det) begin
			state_d = twrs_pkg::DS_IDLE; // RULE3
		end else begin
			unique case (state_q)
				twrs_pkg::DS_IDLE, twrs_pkg::DS_IGNORE: state_d = state_q; // RULE15
				twrs_pkg::DS_RX: begin
					if (scl_rise && bit_q != twrs_pkg::BIT_ACK) begin
						sh_d  = {sh_q[6:0], sda_s_q}; // RULE16
						bit_d = bit_q + 4'h1;
					end else if (scl_fall && bit_q == twrs_pkg::BIT_ACK) begin
						state_d = twrs_pkg::DS_ACK_OUT; // RULE4
						unique case (role_q)
							twrs_pkg::RL_ADDR: begin
								// Direction is the last bit of the byte.
								role_d = sh_q[0] ? twrs_pkg::RL_RHI // RULE5
									: twrs_pkg::RL_REG;
								if (!addr_hit) begin
									state_d = twrs_pkg::DS_IGNORE; // RULE15
								end
							end
							twrs_pkg::RL_REG: begin
								index_d = {8'h00, sh_q}; // RULE8
								role_d  = twrs_pkg::RL_DHI;
							end
							twrs_pkg::RL_DHI: begin
								hi_d   = sh_q; // RULE16
								role_d = twrs_pkg::RL_DLO;
							end
							twrs_pkg::RL_DLO: begin
								wr_stb_d   = 1'h1;
								wr_index_d = index_q;
								wr_data_d  = {hi_q, sh_q}; // RULE16
								srst_d     = index_q == twrs_pkg::SWRST_INDEX;
								index_d    = srst_d ? twrs_pkg::INDEX_RESET // RULE14
									: index_q + 16'h0001;
								role_d = twrs_pkg::RL_DHI;
							end
							default: state_d = twrs_pkg::DS_IGNORE;
						endcase
					end
				end
				twrs_pkg::DS_ACK_OUT: begin
					if (scl_fall) begin
						bit_d = 4'h0;
						if (role_q == twrs_pkg::RL_RHI) begin
							state_d = twrs_pkg::DS_TX; // RULE10
							sh_d    = i_rd_data[15:8];
							lo_d    = i_rd_data[7:0];
						end else begin
							state_d = twrs_pkg::DS_RX;
						end
					end
				end
				twrs_pkg::DS_TX: begin
					if (scl_fall) begin
						if (bit_q == twrs_pkg::BIT_LAST) begin
							state_d = twrs_pkg::DS_ACK_IN; // RULE4
						end else begin
							sh_d  = {sh_q[6:0], 1'h0}; // RULE16
							bit_d = bit_q + 4'h1;
						end
					end
				end
				twrs_pkg::DS_ACK_IN: begin
					if (scl_rise) begin
						nack_d = sda_s_q;
						// An acked low byte steps the index; the add wraps to 0.
						if (!sda_s_q && role_q == twrs_pkg::RL_RLO) begin
							index_d = index_q + 16'h0001; // RULE11 RULE12
						end
					end else if (scl_fall) begin
						bit_d = 4'h0;
						if (nack_q) begin
							state_d = twrs_pkg::DS_IGNORE;
						end else if (role_q == twrs_pkg::RL_RHI) begin
							state_d = twrs_pkg::DS_TX;
							sh_d    = lo_q;
							role_d  = twrs_pkg::RL_RLO;
						end else begin
							state_d = twrs_pkg::DS_TX; // RULE13
							sh_d    = i_rd_data[15:8];
							lo_d    = i_rd_data[7:0];
							role_d  = twrs_pkg::RL_RHI;
						end
					end
				end
			endcase
		end
	end

	// Data line is pulled only for an ack or a zero data bit.
	assign pull_low = (state_q == twrs_pkg::DS_ACK_OUT) || // RULE7
		(state_q == twrs_pkg::DS_TX && !sh_q[7]);

	// State registers.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			state_q <= twrs_pkg::DS_IDLE;
			role_q  <= twrs_pkg::RL_ADDR;
			bit_q   <= 4'h0;
			sh_q    <= 8'h00;
			nack_q  <= 1'h0;
			index_q <= twrs_pkg::INDEX_RESET;
			hi_q    <= 8'h00;
			lo_q    <= 8'h00;
		end else begin
			state_q <= state_d;
			role_q  <= role_d;
			bit_q   <= bit_d;
			sh_q    <= sh_d;
			nack_q  <= nack_d;
			index_q <= index_d;
			hi_q    <= hi_d;
			lo_q    <= lo_d;
		end
	end

	// Output registers toward the register file and the line.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			wr_stb_q   <= 1'h0;
			wr_index_q <= 16'h0000;
			wr_data_q  <= 16'h0000;
			srst_q     <= 1'h0;
			sda_oe_n_q <= 1'h1;
		end else begin
			wr_stb_q   <= wr_stb_d;
			wr_index_q <= wr_index_d;
			wr_data_q  <= wr_data_d;
			srst_q     <= srst_d; // RULE14
			sda_oe_n_q <= !pull_low;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// The clock line has no driver here at all.
	assign bus.d_sda_o    = 1'h0; // RULE1
	assign bus.d_sda_oe_n = sda_oe_n_q;
	assign o_wr_stb       = wr_stb_q;
	assign o_wr_index     = wr_index_q;
	assign o_wr_data      = wr_data_q;
	assign o_soft_reset   = srst_q;
	assign o_rd_index     = index_q;

endmodule : twrs_device

`default_nettype wire

/* File: testbench/twrs_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Link watcher between the two ends
// ----------------------------------------------------------------
module twrs_properties (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic m_sda_oe_n,
	input wire logic d_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic       first_q;
	logic       rd_q;
	logic       nak_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	wire        rise;
	wire        start;

	// Clock rises and start edges, seen against last cycle's lines.
	assign rise  = scl & ~scl_q;
	assign start = scl & scl_q & sda_q & ~sda;

	// Bit position, first byte flag, direction and last ack level.
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			scl_q   <= 1'h1;
			sda_q   <= 1'h1;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			first_q <= 1'h0;
			rd_q    <= 1'h0;
			nak_q   <= 1'h0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start) begin
				cnt_q   <= 4'h0;
				first_q <= 1'h1;
				rd_q    <= 1'h0;
				nak_q   <= 1'h0;
			end else if (rise && cnt_q != 4'h8) begin
				cnt_q <= cnt_q + 4'h1;
				sh_q  <= {sh_q[6:0], sda};
			end else if (rise) begin
				cnt_q   <= 4'h0;
				first_q <= 1'h0;
				nak_q   <= sda;
				rd_q    <= first_q ? sh_q[0] : rd_q;
			end
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	// Start and stop framing.
	a_start_master: assert property (
		scl && scl_q && sda_q && !sda |-> !m_sda_oe_n && d_sda_oe_n)
		else $error("start not made by the master alone");
	a_stop_idle: assert property (
		scl && scl_q && !sda_q && sda |-> d_sda_oe_n [*8])
		else $error("device drives the line after a stop");
	a_steady_high: assert property (
		scl && scl_q |-> $stable(d_sda_oe_n))
		else $error("device data moved while clock high");
	// Acknowledge slots and releases.
	a_addr_ack: assert property (
		rise && cnt_q == 4'h8 && first_q && sh_q[7:1] == 7'h1B
		|-> !d_sda_oe_n) else $error("own address not acknowledged");
	a_write_ack: assert property (
		rise && cnt_q == 4'h8 && !first_q && !rd_q |-> !d_sda_oe_n)
		else $error("written byte not acknowledged");
	a_write_release: assert property (
		rise && cnt_q != 4'h8 && !rd_q |-> d_sda_oe_n)
		else $error("device drives during master bits");
	a_read_master_off: assert property (
		rise && cnt_q != 4'h8 && rd_q && !nak_q |-> m_sda_oe_n)
		else $error("master drives during read bits");
	a_read_ack_free: assert property (
		rise && cnt_q == 4'h8 && rd_q && !first_q |-> d_sda_oe_n)
		else $error("device holds line in master ack slot");
endmodule : twrs_properties

`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        core_clk = 1'h0;
	logic        reset_n  = 1'h0;
	logic        go       = 1'h0;
	logic        rd       = 1'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] wdata    = 16'h0000;
	logic        busy, done, nack, wr_stb, soft_reset, wr_stb2, ack;
	logic [15:0] rdata, wr_index, wr_data, rd_index, rd_data;
	logic [15:0] rd_index2, rd_data2;
	logic [7:0]  mon_addr = 8'h00;
	logic [7:0]  v_hi, v_lo;
	logic        mon_ack  = 1'h1;
	int          miscompares = 0;
	int          n_tests     = 0;
	int          wr_cnt = 0, sr_cnt = 0, wr_cnt2 = 0, mon_n = 99;

	twrs_if bus ();
	twrs_if bus2 ();

	// ----------------------------------------------------------------
	// Clock, register contents and the two links
	// ----------------------------------------------------------------
	always #2.5 core_clk = ~core_clk;
	assign rd_data  = {rd_index[7:0] ^ 8'hC3, rd_index[7:0]};
	assign rd_data2 = {rd_index2[7:0] ^ 8'hC3, rd_index2[7:0]};
	assign bus2.m_scl_o = 1'h0;
	assign bus2.m_sda_o = 1'h0;

	twrs_master twrs_master_inst (.i_core_clk(core_clk),
		.i_reset_n(reset_n), .bus(bus.master), .i_go(go), .i_read(rd),
		.i_reg(reg_addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
		.o_nack(nack), .o_rdata(rdata));
	twrs_device twrs_device_inst (.i_core_clk(core_clk),
		.i_reset_n(reset_n), .bus(bus.device), .o_wr_stb(wr_stb),
		.o_wr_index(wr_index), .o_wr_data(wr_data),
		.o_soft_reset(soft_reset), .o_rd_index(rd_index),
		.i_rd_data(rd_data));
	twrs_device twrs_device_inst2 (.i_core_clk(core_clk),
		.i_reset_n(reset_n), .bus(bus2.device), .o_wr_stb(wr_stb2),
		.o_wr_index(), .o_wr_data(), .o_soft_reset(),
		.o_rd_index(rd_index2), .i_rd_data(rd_data2));
	twrs_properties twrs_properties_inst (.i_core_clk(core_clk),
		.i_reset_n(reset_n), .m_sda_oe_n(bus.m_sda_oe_n),
		.d_sda_oe_n(bus.d_sda_oe_n), .scl(bus.scl), .sda(bus.sda));

	// Counts write pulses from both device ends and reset pulses from the first.
	always @(posedge core_clk) begin
		wr_cnt  += (wr_stb === 1'h1);
		sr_cnt  += (soft_reset === 1'h1);
		wr_cnt2 += (wr_stb2 === 1'h1);
	end

	// Captures the first byte and its ack slot after each start.
	always @(negedge bus.sda) if (bus.scl === 1'h1) mon_n = 0;
	always @(posedge bus.scl) begin
		if (mon_n < 8) mon_addr = {mon_addr[6:0], bus.sda};
		if (mon_n == 8) mon_ack = bus.sda;
		mon_n++;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Issues one master command and waits for its completion pulse.
	task mcmd(input logic r, input logic [7:0] a, input logic [15:0] d);
		int n;
		@(posedge core_clk);
		#1;
		go = 1'h1;
		rd = r;
		reg_addr = a;
		wdata = d;
		@(posedge core_clk);
		#1;
		go = 1'h0;
		chk({15'h0000, busy}, 16'h0001);
		n = 0;
		while (done !== 1'h1 && n < 40000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(16'(n < 40000), 16'h0001);
	endtask : mcmd

	// One bit on the second link: data set while low, sampled late high.
	task bb_bit(input logic b, output logic r);
		#8 bus2.m_sda_oe_n = b;
		#16 bus2.m_scl_oe_n = 1'h1;
		#22 r = bus2.sda;
		#2 bus2.m_scl_oe_n = 1'h0;
	endtask : bb_bit

	task bb_start;
		#24 bus2.m_sda_oe_n = 1'h1;
		#24 bus2.m_scl_oe_n = 1'h1;
		#24 bus2.m_sda_oe_n = 1'h0;
		#24 bus2.m_scl_oe_n = 1'h0;
	endtask : bb_start

	task bb_stop;
		#8 bus2.m_sda_oe_n = 1'h0;
		#24 bus2.m_scl_oe_n = 1'h1;
		#24 bus2.m_sda_oe_n = 1'h1;
		#100;
	endtask : bb_stop

	task bb_byte(input logic [7:0] b, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) bb_bit(b[i], r);
		bb_bit(1'h1, a);
	endtask : bb_byte

	task bb_read(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) bb_bit(1'h1, v[i]);
		bb_bit(last, r);
	endtask : bb_read

	task end_sim;
		if (miscompares == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		bus2.m_scl_oe_n = 1'h1;
		bus2.m_sda_oe_n = 1'h1;
		repeat (2) @(posedge core_clk);
		#1;
		reset_n = 1'h1;
		repeat (4) @(posedge core_clk);
		mcmd(1'h0, 8'h05, 16'hA5C3);
		chk(wr_index, 16'h0005);
		chk(wr_data, 16'hA5C3);
		chk(16'(wr_cnt), 16'h0001);
		chk(16'(sr_cnt), 16'h0000);
		chk(rd_index, 16'h0006);
		chk({8'h00, mon_addr}, 16'h0036);
		chk({15'h0000, mon_ack}, 16'h0000);
		chk({13'h0000, nack, bus.scl, bus.sda}, 16'h0003);
		// Back to back write of the reset register.
		mcmd(1'h0, 8'h00, 16'h1234);
		chk(16'(sr_cnt), 16'h0001);
		chk(wr_index, 16'h0000);
		chk(rd_index, 16'h0000);
		mcmd(1'h1, 8'h12, 16'h0000);
		chk(rdata, {8'h12 ^ 8'hC3, 8'h12});
		chk({8'h00, mon_addr}, 16'h0037);
		chk({13'h0000, nack, bus.scl, bus.sda}, 16'h0003);
		chk(16'(wr_cnt), 16'h0002);
		// Foreign address, then a new start with the own address.
		bb_start;
		bb_byte(8'h54, ack);
		chk({15'h0000, ack}, 16'h0001);
		bb_byte(8'h36, ack);
		chk({15'h0000, ack}, 16'h0001);
		bb_start;
		bb_byte(8'h36, ack);
		chk({15'h0000, ack}, 16'h0000);
		bb_byte(8'h20, ack);
		chk({15'h0000, ack}, 16'h0000);
		bb_start;
		bb_byte(8'h37, ack);
		chk({15'h0000, ack}, 16'h0000);
		bb_read(1'h0, v_hi);
		bb_read(1'h0, v_lo);
		chk({v_hi, v_lo}, {8'h20 ^ 8'hC3, 8'h20});
		bb_read(1'h0, v_hi);
		bb_read(1'h1, v_lo);
		chk({v_hi, v_lo}, {8'h21 ^ 8'hC3, 8'h21});
		bb_stop;
		chk(16'(wr_cnt2), 16'h0000);
		chk({15'h0000, bus2.sda}, 16'h0001);
		end_sim;
	end

	// Cuts a hang short well after the expected run length.
	initial begin
		#450000;
		miscompares++;
		end_sim;
	end
endmodule : testbench

`default_nettype wire
